/* pkg/rs_pkg.sv */
// Constants and types for the instruction-semantics core
// Contract
// [RULE1] Each instruction is one 16-bit halfword.
// [RULE2] Basic instructions issue one per clock.
// [RULE3] Arithmetic 32-bit; loaded bytes/words sign-extend.
// [RULE4] Immediates: arithmetic sign-extend, logical zero-extend.
// [RULE5] Register operands only; bit ops modify memory.
// [RULE6] Unconditional jump always runs its delay slot.
// [RULE7] Conditional branches: plain and delayed variants.
// [RULE8] 16x16 multiply 1-2, accumulate 2-3 cycles.
// [RULE9] 32x32 multiply and accumulate 2-4 cycles.
// [RULE10] Compares set flag; branches test only it.
// [RULE11] Signed ge and equal-zero compare semantics.
// [RULE12] Addition leaves the compare flag alone.
// [RULE13] Set-branch on flag 1, clear-branch on 0.
// [RULE14] 8-bit immediate inline; wider from literal table.
// [RULE15] Literal move uses PC-relative displacement load.
// [RULE16] Compare flag is status bit 0, also carry.
// [RULE17] PC-relative base is instruction address plus four.
// [RULE18] Branch in delay slot is illegal, not executed.
`default_nettype none
package rs_pkg;
	// Fetch stepping and PC-relative base
	localparam logic [31:0] INSN_STEP = 32'h0000_0002;
	localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
	// Issue rate: one core clock per basic instruction
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned ISSUE_CYC = 1;
	// Multiplier latencies, issue cycle included
	localparam logic [2:0] MUL16_CYC = 3'h2;
	localparam logic [2:0] MAC16_CYC = 3'h3;
	localparam logic [2:0] MUL32_CYC = 3'h4;
	localparam logic [2:0] MAC32_CYC = 3'h4;
	// Status word
	localparam int unsigned SR_T_BIT = 0;
	localparam logic [31:0] SR_RESET = 32'h0000_00f0;
	// Major opcodes, bits 15:12
	localparam logic [3:0] OP_ALU = 4'h0;
	localparam logic [3:0] OP_ADDI = 4'h1;
	localparam logic [3:0] OP_MOVI = 4'h2;
	localparam logic [3:0] OP_CMPEQI = 4'h3;
	localparam logic [3:0] OP_ANDI = 4'h4;
	localparam logic [3:0] OP_ORI = 4'h5;
	localparam logic [3:0] OP_XORI = 4'h6;
	localparam logic [3:0] OP_LITW = 4'h7;
	localparam logic [3:0] OP_LITL = 4'h8;
	localparam logic [3:0] OP_LD = 4'h9;
	localparam logic [3:0] OP_ST = 4'ha;
	localparam logic [3:0] OP_BRA = 4'hb;
	localparam logic [3:0] OP_BCOND = 4'hc;
	localparam logic [3:0] OP_RMW = 4'hd;
	// Register-register functions, bits 3:0
	localparam logic [3:0] FN_ADD = 4'h0;
	localparam logic [3:0] FN_ADDC = 4'h1;
	localparam logic [3:0] FN_AND = 4'h2;
	localparam logic [3:0] FN_OR = 4'h3;
	localparam logic [3:0] FN_XOR = 4'h4;
	localparam logic [3:0] FN_MOV = 4'h5;
	localparam logic [3:0] FN_CMPGE = 4'h6;
	localparam logic [3:0] FN_CMPEQ = 4'h7;
	localparam logic [3:0] FN_MUL16 = 4'h8;
	localparam logic [3:0] FN_MUL32 = 4'h9;
	localparam logic [3:0] FN_MAC16 = 4'ha;
	localparam logic [3:0] FN_MAC32 = 4'hb;
	localparam logic [3:0] FN_STSL = 4'hc;
	localparam logic [3:0] FN_STSH = 4'hd;
	// Bit-op functions for memory modify
	localparam logic [1:0] RMW_AND = 2'h0;
	localparam logic [1:0] RMW_OR = 2'h1;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} rs_size_e;
	typedef enum logic [1:0] {S_RUN, S_MEM, S_MUL} rs_state_e;
	typedef struct packed {
		logic req;
		logic we;
		rs_size_e size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} rs_dreq_s;
endpackage : rs_pkg
`default_nettype wire

/* design/rs_core.sv */
// Instruction fetch, decode and execute core with delayed branching
`timescale 1ns/10ps
`default_nettype none
module rs_core
	import rs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Instruction fetch port
	output logic fetch_req_out,
	output logic [31:0] fetch_addr_out,
	input wire logic [15:0] instr_in,
	input wire logic instr_valid_in,
	// Data port
	output rs_dreq_s dreq_out,
	input wire logic [31:0] drdata_in,
	input wire logic dack_in,
	// Status
	output logic [31:0] status_word_out,
	output logic illegal_slot_out
);
	logic [31:0] gpr [16];
	logic [31:0] fpc;
	logic [31:0] ir_addr;
	logic [31:0] sr;
	logic [31:0] pend_tgt;
	logic [15:0] ir;
	logic ir_valid;
	logic ir_slot;
	logic pend;
	logic [63:0] mac;
	logic [63:0] mul_acc;
	logic [2:0] mul_cnt;
	rs_state_e st;
	rs_dreq_s dreq;
	logic [3:0] mem_rd;
	logic mem_load;
	logic mem_rmw;
	logic [1:0] rmw_fn;
	logic [7:0] rmw_imm;
	logic slot_err;

	// Field decode
	// [RULE1] Fixed halfword fields
	wire [3:0] op = ir[15:12];
	wire [3:0] rn = ir[11:8];
	wire [3:0] rm = ir[7:4];
	wire [3:0] fn = ir[3:0];
	// [RULE14] Inline 8-bit immediate
	wire [7:0] imm8 = ir[7:0];
	// [RULE4] Sign or zero extension
	wire [31:0] imm_s = {{24{imm8[7]}}, imm8};
	wire [31:0] imm_z = {24'h00_0000, imm8};
	wire [31:0] rn_v = gpr[rn];
	wire [31:0] rm_v = gpr[rm];
	wire [31:0] r0_v = gpr[0];
	// [RULE16] Flag at bit 0
	wire t = sr[SR_T_BIT];
	wire [1:0] sz_f = fn[1:0];

	// [RULE17] Base two instructions ahead
	wire [31:0] pc_rel = ir_addr + PC_AHEAD;
	wire [31:0] lit_w_ea = pc_rel + {23'h00_0000, imm8, 1'b0};
	wire [31:0] lit_l_ea = {pc_rel[31:2], 2'b00} + {22'h00_0000, imm8, 2'b00};
	wire [31:0] bra_tgt = pc_rel + {{19{ir[11]}}, ir[11:0], 1'b0};
	wire [31:0] bc_tgt = pc_rel + {{23{imm8[7]}}, imm8, 1'b0};

	// Branch decode
	wire run = st == S_RUN;
	// [RULE2] One issue slot per clock
	wire exec = run && ir_valid;
	wire is_bra = op == OP_BRA;
	wire is_bc = op == OP_BCOND;
	// [RULE13] Set variant on 1, clear on 0
	// [RULE10] Decided only by the flag
	wire bc_take = is_bc && (t != rn[0]);
	// [RULE6] Unconditional is always delayed
	// [RULE7] Delayed variant selected by bit 9
	wire br_dly = is_bra || (is_bc && rn[1]);
	wire br_take = is_bra || bc_take;
	wire [31:0] br_tgt = is_bra ? bra_tgt : bc_tgt;
	// [RULE18] Branch in slot dropped
	wire slot_bad = exec && ir_slot && (is_bra || is_bc);
	wire go = exec && !slot_bad;
	wire take_now = go && br_take && !br_dly;
	wire take_dly = go && br_take && br_dly;
	wire slot_fetch = take_dly || pend;
	wire [31:0] slot_tgt = take_dly ? br_tgt : pend_tgt;

	// Arithmetic helpers
	wire [32:0] addc = {1'b0, rn_v} + {1'b0, rm_v} + {32'h0000_0000, t};
	wire signed [31:0] p16 = $signed(rn_v[15:0]) * $signed(rm_v[15:0]);
	wire signed [63:0] p32 = $signed(rn_v) * $signed(rm_v);
	wire [63:0] p16_x = {{32{p16[31]}}, p16};
	wire [63:0] mac16 = mac + p16_x;
	wire [63:0] mac32 = mac + p32;

	// [RULE3] Loaded byte or word sign-extended
	wire [31:0] ld_ext = (dreq.size == SZ_BYTE) ? {{24{drdata_in[7]}}, drdata_in[7:0]} :
		(dreq.size == SZ_WORD) ? {{16{drdata_in[15]}}, drdata_in[15:0]} : drdata_in;
	wire [7:0] rmw_res = (rmw_fn == RMW_AND) ? (drdata_in[7:0] & rmw_imm) :
		(rmw_fn == RMW_OR) ? (drdata_in[7:0] | rmw_imm) : (drdata_in[7:0] ^ rmw_imm);
	wire ld_done = (st == S_MEM) && dack_in && mem_load;

	logic wb_en;
	logic [3:0] wb_idx;
	logic [31:0] wb_data;
	logic t_we;
	logic t_val;
	logic mul_go;
	logic [2:0] mul_len;
	logic [63:0] mul_val;
	rs_dreq_s mreq;
	logic m_load;
	logic m_rmw;

	always_comb begin
		wb_en = 1'b0;
		wb_idx = rn;
		wb_data = 32'h0000_0000;
		t_we = 1'b0;
		t_val = t;
		mul_go = 1'b0;
		mul_len = MUL16_CYC;
		mul_val = mac;
		mreq = '0;
		m_load = 1'b0;
		m_rmw = 1'b0;
		if (ld_done) begin
			wb_en = 1'b1;
			wb_idx = mem_rd;
			wb_data = ld_ext;
		end else if (go) begin
			case (op)
				OP_ALU: begin
					case (fn)
						// [RULE12] Plain add keeps flag
						FN_ADD: begin
							wb_en = 1'b1;
							wb_data = rn_v + rm_v;
						end
						// [RULE16] Carry into flag
						FN_ADDC: begin
							wb_en = 1'b1;
							wb_data = addc[31:0];
							t_we = 1'b1;
							t_val = addc[32];
						end
						FN_AND: begin
							wb_en = 1'b1;
							wb_data = rn_v & rm_v;
						end
						FN_OR: begin
							wb_en = 1'b1;
							wb_data = rn_v | rm_v;
						end
						FN_XOR: begin
							wb_en = 1'b1;
							wb_data = rn_v ^ rm_v;
						end
						FN_MOV: begin
							wb_en = 1'b1;
							wb_data = rm_v;
						end
						// [RULE11] First register signed ge second
						FN_CMPGE: begin
							t_we = 1'b1;
							t_val = $signed(rn_v) >= $signed(rm_v);
						end
						// [RULE10] Compare result to flag
						FN_CMPEQ: begin
							t_we = 1'b1;
							t_val = rn_v == rm_v;
						end
						// [RULE8] Short multiply and accumulate
						FN_MUL16: begin
							mul_go = 1'b1;
							mul_val = {mac[63:32], p16};
						end
						FN_MAC16: begin
							mul_go = 1'b1;
							mul_len = MAC16_CYC;
							mul_val = mac16;
						end
						// [RULE9] Long multiply and accumulate
						FN_MUL32: begin
							mul_go = 1'b1;
							mul_len = MUL32_CYC;
							mul_val = p32;
						end
						FN_MAC32: begin
							mul_go = 1'b1;
							mul_len = MAC32_CYC;
							mul_val = mac32;
						end
						FN_STSL: begin
							wb_en = 1'b1;
							wb_data = mac[31:0];
						end
						FN_STSH: begin
							wb_en = 1'b1;
							wb_data = mac[63:32];
						end
						default: begin
						end
					endcase
				end
				// [RULE4] Arithmetic immediate sign-extended
				OP_ADDI: begin
					wb_en = 1'b1;
					wb_data = rn_v + imm_s;
				end
				OP_MOVI: begin
					wb_en = 1'b1;
					wb_data = imm_s;
				end
				// [RULE11] Equal against immediate
				OP_CMPEQI: begin
					t_we = 1'b1;
					t_val = rn_v == imm_s;
				end
				// [RULE4] Logical immediate zero-extended
				OP_ANDI: begin
					wb_en = 1'b1;
					wb_data = rn_v & imm_z;
				end
				OP_ORI: begin
					wb_en = 1'b1;
					wb_data = rn_v | imm_z;
				end
				OP_XORI: begin
					wb_en = 1'b1;
					wb_data = rn_v ^ imm_z;
				end
				// [RULE15] Literal-table word load
				OP_LITW: begin
					mreq.req = 1'b1;
					mreq.size = SZ_WORD;
					mreq.addr = lit_w_ea;
					m_load = 1'b1;
				end
				// [RULE15] Literal-table long load
				OP_LITL: begin
					mreq.req = 1'b1;
					mreq.size = SZ_LONG;
					mreq.addr = lit_l_ea;
					m_load = 1'b1;
				end
				// [RULE5] Memory through load, store, literal load and bit op
				OP_LD: begin
					mreq.req = 1'b1;
					mreq.size = (sz_f == 2'h3) ? SZ_LONG : rs_size_e'(sz_f);
					mreq.addr = rm_v;
					m_load = 1'b1;
				end
				OP_ST: begin
					mreq.req = 1'b1;
					mreq.we = 1'b1;
					mreq.size = (sz_f == 2'h3) ? SZ_LONG : rs_size_e'(sz_f);
					mreq.addr = rn_v;
					mreq.wdata = rm_v;
				end
				// [RULE5] Bit op on memory byte
				OP_RMW: begin
					mreq.req = 1'b1;
					mreq.size = SZ_BYTE;
					mreq.addr = r0_v;
					m_rmw = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// Sequencer for memory and multiplier stalls
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st <= S_RUN;
			dreq <= '0;
			mem_rd <= 4'h0;
			mem_load <= 1'b0;
			mem_rmw <= 1'b0;
			rmw_fn <= 2'h0;
			rmw_imm <= 8'h00;
			mul_acc <= 64'h0000_0000_0000_0000;
			mul_cnt <= 3'h0;
			mac <= 64'h0000_0000_0000_0000;
		end else begin
			case (st)
				S_RUN: begin
					if (mreq.req) begin
						dreq <= mreq;
						mem_rd <= rn;
						mem_load <= m_load;
						mem_rmw <= m_rmw;
						rmw_fn <= fn[1:0];
						rmw_imm <= imm8;
						st <= S_MEM;
					end else if (mul_go) begin
						mul_acc <= mul_val;
						mul_cnt <= mul_len - 3'h1;
						st <= S_MUL;
					end
				end
				S_MEM: begin
					// [RULE5] Read, modify, write back
					if (dack_in && mem_rmw) begin
						dreq.we <= 1'b1;
						dreq.wdata <= {24'h00_0000, rmw_res};
						mem_rmw <= 1'b0;
					end else if (dack_in) begin
						dreq.req <= 1'b0;
						mem_load <= 1'b0;
						st <= S_RUN;
					end
				end
				S_MUL: begin
					if (mul_cnt == 3'h1) begin
						mac <= mul_acc;
						st <= S_RUN;
					end else begin
						mul_cnt <= mul_cnt - 3'h1;
					end
				end
				default: st <= S_RUN;
			endcase
		end
	end

	// Fetch and instruction register
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fpc <= 32'h0000_0000;
			ir <= 16'h0000;
			ir_addr <= 32'h0000_0000;
			ir_valid <= 1'b0;
			ir_slot <= 1'b0;
			pend <= 1'b0;
			pend_tgt <= 32'h0000_0000;
		end else if (take_now) begin
			// [RULE7] Non-delayed: discard following fetch
			fpc <= br_tgt;
			ir_valid <= 1'b0;
			ir_slot <= 1'b0;
		end else if (run && instr_valid_in) begin
			ir <= instr_in;
			ir_addr <= fpc;
			ir_valid <= 1'b1;
			// [RULE6] Slot runs, then redirect
			ir_slot <= slot_fetch;
			pend <= 1'b0;
			// [RULE1] Advance one halfword
			fpc <= slot_fetch ? slot_tgt : fpc + INSN_STEP;
		end else if (run) begin
			ir_valid <= 1'b0;
			if (take_dly) begin
				pend <= 1'b1;
				pend_tgt <= br_tgt;
			end
		end
	end

	// Status word and slot error
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sr <= SR_RESET;
			slot_err <= 1'b0;
		end else begin
			// [RULE10] Only compares and carry ops write flag
			if (t_we)
				sr[SR_T_BIT] <= t_val;
			slot_err <= slot_bad;
		end
	end

	// General registers, not reset
	always_ff @(posedge clk_sys_in) begin
		if (wb_en)
			gpr[wb_idx] <= wb_data;
	end

	assign fetch_req_out = run;
	assign fetch_addr_out = fpc;
	assign dreq_out = dreq;
	assign status_word_out = sr;
	assign illegal_slot_out = slot_err;
endmodule : rs_core
`default_nettype wire

/* testbench/rs_core_chk.sv */
// Port checker for the instruction-semantics core
`timescale 1ns/10ps
`default_nettype none
module rs_core_chk
	import rs_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic nrst_in,
	// Fetch
	input wire logic fetch_req_out,
	input wire logic [31:0] fetch_addr_out,
	input wire logic [15:0] instr_in,
	input wire logic instr_valid_in,
	// Data and status
	input wire rs_dreq_s dreq_out,
	input wire logic [31:0] drdata_in,
	input wire logic dack_in,
	input wire logic [31:0] status_word_out,
	input wire logic illegal_slot_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!nrst_in);
	logic take;
	logic is_br;
	logic is_cmp;
	logic last_br;
	logic last_jmp;
	logic ex_cmp;
	logic is_slow;
	logic last_slow;
	logic [31:0] lit_addr;
	assign take = fetch_req_out && instr_valid_in;
	assign is_br = instr_in[15:12] == OP_BRA || instr_in[15:12] == OP_BCOND;
	assign is_cmp = instr_in[15:12] == OP_CMPEQI || (instr_in[15:12] == OP_ALU
		&& instr_in[3:0] inside {FN_ADDC, FN_CMPGE, FN_CMPEQ});
	// Memory and multiply ops stall the instruction fetched behind them
	assign is_slow = instr_in[15:12] inside {OP_LITW, OP_LITL, OP_LD, OP_ST, OP_RMW}
		|| (instr_in[15:12] == OP_ALU
		&& instr_in[3:0] inside {FN_MUL16, FN_MUL32, FN_MAC16, FN_MAC32});
	assign lit_addr = fetch_addr_out + PC_AHEAD + {23'h0, instr_in[7:0], 1'b0};
	// Tracks the last instruction taken from the fetch port
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			last_br <= 1'b0;
			last_jmp <= 1'b0;
			ex_cmp <= 1'b0;
			last_slow <= 1'b0;
		end else if (take) begin
			last_br <= is_br;
			last_jmp <= instr_in[15:12] == OP_BRA;
			ex_cmp <= is_cmp;
			last_slow <= is_slow;
		end
	end
	sequence s_slot_br;
		take && last_jmp && is_br;
	endsequence
	sequence s_lit_fetch;
		take && !last_br && !last_slow && instr_in[15:12] == OP_LITW;
	endsequence
	chk_fetch_step: assert property (take && !last_br |=>
		fetch_addr_out == $past(fetch_addr_out) + INSN_STEP) else $error("fetch step wrong");
	chk_reset_status: assert property ($rose(nrst_in) |->
		status_word_out == SR_RESET) else $error("status reset value wrong");
	chk_status_fixed: assert property (status_word_out[31:1] == SR_RESET[31:1])
		else $error("status high bits changed");
	chk_flag_cause: assert property ($changed(status_word_out[0]) |-> $past(ex_cmp))
		else $error("flag changed without compare");
	chk_mem_stall: assert property (dreq_out.req |-> !fetch_req_out)
		else $error("fetch during data access");
	chk_req_hold: assert property (dreq_out.req && !dack_in |=> dreq_out.req
		&& $stable(dreq_out.addr) && $stable(dreq_out.size) && $stable(dreq_out.we))
		else $error("data request not held");
	chk_write_end: assert property (dreq_out.req && dack_in && dreq_out.we |=>
		!dreq_out.req) else $error("write access not ended");
	chk_slot_flag: assert property (s_slot_br |-> ##[1:3] illegal_slot_out)
		else $error("slot branch not flagged");
	chk_slot_pulse: assert property (illegal_slot_out |=> !illegal_slot_out)
		else $error("slot flag too long");
	chk_lit_addr: assert property (s_lit_fetch |-> ##2 dreq_out.req
		&& dreq_out.addr == $past(lit_addr, 2)) else $error("literal address wrong");
endmodule : rs_core_chk
bind rs_core rs_core_chk u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
	.fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out), .instr_in(instr_in),
	.instr_valid_in(instr_valid_in), .dreq_out(dreq_out), .drdata_in(drdata_in),
	.dack_in(dack_in), .status_word_out(status_word_out), .illegal_slot_out(illegal_slot_out));
`default_nettype wire

/* testbench/rs_mem_model.sv */
// Behavioural instruction and data memory facing the core
`timescale 1ns/10ps
`default_nettype none
module rs_mem_model
	import rs_pkg::*;
(
	// Clock and pace
	input wire logic clk_sys_in,
	input wire logic slow_in,
	// Fetch side
	input wire logic [31:0] fetch_addr_in,
	output logic [15:0] instr_out,
	output logic valid_out,
	// Data side
	input wire rs_dreq_s dreq_in,
	output logic [31:0] rdata_out,
	output logic ack_out
);
	logic [15:0] imem [0:31];
	logic [7:0] dmem [0:255];
	logic [1:0] wait_cnt = 2'h0;
	logic [7:0] a;
	assign a = dreq_in.addr[7:0];
	assign instr_out = valid_out ? imem[fetch_addr_in[5:1]] : ~imem[fetch_addr_in[5:1]];
	initial begin
		valid_out = 1'b1;
		ack_out = 1'b0;
		rdata_out = 32'h0;
		foreach (dmem[k]) dmem[k] = 8'h5a;
	end
	// Slow pace adds fetch bubbles and three wait cycles
	always @(posedge clk_sys_in) begin
		valid_out <= !slow_in || !valid_out;
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (dreq_in.req && !ack_out && wait_cnt == {2{slow_in}}) begin
			wait_cnt <= 2'h0;
			ack_out <= 1'b1;
			rdata_out <= {dmem[a + 8'h3], dmem[a + 8'h2], dmem[a + 8'h1], dmem[a]};
			if (dreq_in.we) begin
				dmem[a] <= dreq_in.wdata[7:0];
				if (dreq_in.size != SZ_BYTE) dmem[a + 8'h1] <= dreq_in.wdata[15:8];
				if (dreq_in.size == SZ_LONG) dmem[a + 8'h2] <= dreq_in.wdata[23:16];
				if (dreq_in.size == SZ_LONG) dmem[a + 8'h3] <= dreq_in.wdata[31:24];
			end
		end else if (dreq_in.req && !ack_out) begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
endmodule : rs_mem_model
`default_nettype wire

/* testbench/risc_instruction_semantics_test.sv */
// Self-checking bench for the instruction-semantics core
`timescale 1ns/10ps
`default_nettype none
module risc_instruction_semantics_test
	import rs_pkg::*;
;
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic slow = 1'b0;
	logic slot_seen = 1'b0;
	logic fetch_req, instr_valid, dack, illegal_slot;
	logic [31:0] fetch_addr, drdata, status_word;
	logic [15:0] instr;
	rs_dreq_s dreq;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	rs_core uut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .fetch_req_out(fetch_req),
		.fetch_addr_out(fetch_addr), .instr_in(instr), .instr_valid_in(instr_valid),
		.dreq_out(dreq), .drdata_in(drdata), .dack_in(dack),
		.status_word_out(status_word), .illegal_slot_out(illegal_slot));
	rs_mem_model mem (.clk_sys_in(clk_sys_in), .slow_in(slow), .fetch_addr_in(fetch_addr),
		.instr_out(instr), .valid_out(instr_valid), .dreq_in(dreq), .rdata_out(drdata),
		.ack_out(dack));
	always @(posedge clk_sys_in) begin
		cycles++;
		if (illegal_slot === 1'b1) slot_seen = 1'b1;
		if (cycles == 4000) begin
			n_fail++;
			close_out();
		end
	end
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] rd32(input logic [7:0] a);
		return {mem.dmem[a + 8'h3], mem.dmem[a + 8'h2], mem.dmem[a + 8'h1], mem.dmem[a]};
	endfunction : rd32
	task automatic run(input logic [15:0] prog[], input logic pace);
		int i;
		nrst_in <= 1'b0;
		slow <= pace;
		foreach (prog[k]) mem.imem[k] = prog[k];
		repeat (4) @(posedge clk_sys_in);
		slot_seen = 1'b0;
		nrst_in <= 1'b1;
		for (i = 0; i < 400 && fetch_addr !== 2 * (prog.size() - 2); i++) @(posedge clk_sys_in);
		repeat (12) @(posedge clk_sys_in);
	endtask : run
	task automatic test_ext;
		mem.dmem[8'h60] = 8'h9c;
		mem.dmem[8'h1e] = 8'h34;
		mem.dmem[8'h1f] = 8'h82;
		run('{16'h2240, 16'h2180, 16'ha213, 16'h2344, 16'h4180, 16'ha313, 16'h7407, 16'h2548,
			16'ha543, 16'h2660, 16'h9760, 16'h284c, 16'ha873, 16'hbffe, 16'he000}, 1'b1);
		check("sext imm", rd32(8'h40), 32'hffffff80);
		check("zext imm", rd32(8'h44), 32'h00000080);
		check("word literal", rd32(8'h48), 32'hffff8234);
		check("byte load", rd32(8'h4c), 32'hffffff9c);
		$display("test_ext done");
	endtask : test_ext
	task automatic test_branch(input logic pace);
		mem.dmem[8'h50] = 8'h00;
		run('{16'h2900, 16'h2105, 16'h2203, 16'h0126, 16'hc001, 16'h2977, 16'h2977, 16'h1101,
			16'hc102, 16'hb002, 16'h2a11, 16'h2977, 16'h2977, 16'h3a00, 16'hc302, 16'h2b22,
			16'h2977, 16'h2977, 16'h09a0, 16'h09b0, 16'h2d50, 16'had93, 16'hbffe, 16'he000}, pace);
		check("branch path", rd32(8'h50), 32'h00000033);
		check("final flag", status_word, 32'h000000f0);
		check("no slot flag", {31'h0, slot_seen}, 32'h0);
		$display("test_branch done");
	endtask : test_branch
	task automatic test_mul_rmw;
		mem.dmem[8'h60] = 8'h90;
		{mem.dmem[8'h1b], mem.dmem[8'h1a], mem.dmem[8'h19], mem.dmem[8'h18]} = 32'h40000000;
		run('{16'h2110, 16'h8205, 16'h0129, 16'h030c, 16'h040d, 16'h2558, 16'ha533, 16'h265c,
			16'ha643, 16'h2060, 16'hd00d, 16'hb000, 16'hb000, 16'hbffe, 16'he000}, 1'b0);
		check("product low", rd32(8'h58), 32'h00000000);
		check("product high", rd32(8'h5c), 32'h00000004);
		check("bit modify", {24'h0, mem.dmem[8'h60]}, 32'h0000009d);
		check("slot flag", {31'h0, slot_seen}, 32'h1);
		$display("test_mul_rmw done");
	endtask : test_mul_rmw
	// Carry add, short and long multiply chain, register compare, delayed set-branch
	task automatic test_alu;
		run('{16'h21ff, 16'h2201, 16'h0121, 16'h2305, 16'h24fd, 16'h0348, 16'h034a, 16'h034b,
			16'h050c, 16'h0127, 16'hc001, 16'h2633, 16'h0667, 16'hc202, 16'h6655, 16'h2600,
			16'h2600, 16'h5680, 16'h2770, 16'ha763, 16'h2874, 16'ha853, 16'h2978, 16'ha913,
			16'hbffe, 16'he000}, 1'b0);
		check("logic imm path", rd32(8'h70), 32'h000000e6);
		check("mac chain", rd32(8'h74), 32'hffffffd3);
		check("carry sum", rd32(8'h78), 32'h00000000);
		check("flag after", status_word, 32'h000000f1);
		$display("test_alu done");
	endtask : test_alu
	initial begin
		test_ext();
		test_branch(1'b0);
		test_branch(1'b1);
		test_mul_rmw();
		test_alu();
		close_out();
	end
endmodule : risc_instruction_semantics_test
`default_nettype wire
